// *** include/qdc_pkg.sv ***
// constants shared by the quad converter control core and its trim stage
// assumes one 10 MHz clock and a 24-bit serial frame
package qdc_pkg;

  // ==========================================================================
  // frame layout
  localparam logic [4:0] FRAME_BITS = 5'h18;
  localparam int         RW_BIT     = 23;
  localparam int         ADDR_MSB   = 22;
  localparam int         ADDR_LSB   = 19;
  localparam int         DATA_MSB   = 13;

  // ==========================================================================
  // address map: upper two address bits pick the bank, lower two the channel
  localparam logic [3:0] ADDR_COMMAND = 4'h0;
  localparam logic [1:0] BANK_INPUT   = 2'h1;
  localparam logic [1:0] BANK_OFFSET  = 2'h2;
  localparam logic [1:0] BANK_SLOPE   = 2'h3;

  // ==========================================================================
  // command register fields
  localparam int         CMD_RST_BIT  = 13;
  localparam int         CMD_LOAD_BIT = 12;
  localparam int         CMD_GAIN_MSB = 3;
  localparam int         CMD_GAIN_LSB = 0;
  localparam logic [3:0] GAIN_RESET   = 4'hf;

  // ==========================================================================
  // reset values
  localparam logic [13:0] RESET_CODE_BIP = 14'h0000;
  localparam logic [13:0] RESET_CODE_UNI = 14'h0000;
  localparam logic [8:0]  OFFSET_RESET   = 9'h000;
  localparam logic [7:0]  SLOPE_RESET    = 8'h00;
  localparam logic [6:0]  SYNC_INIT      = 7'h0e;
  localparam logic [1:0]  POR_CYCLES     = 2'h3;

  // ==========================================================================
  // code and trim limits
  localparam int          OFFSET_TRIM_MIN = -256;
  localparam int          OFFSET_TRIM_MAX = 255;
  localparam int          SLOPE_TRIM_MIN  = -128;
  localparam int          SLOPE_TRIM_MAX  = 127;
  localparam int          BIP_CODE_MIN    = -8192;
  localparam int          BIP_CODE_MAX    = 8191;
  localparam int          UNI_CODE_MAX    = 16383;
  localparam logic [13:0] BIP_SAT_LOW     = 14'h2000;
  localparam logic [13:0] BIP_SAT_HIGH    = 14'h1fff;
  localparam logic [13:0] UNI_SAT_LOW     = 14'h0000;
  localparam logic [13:0] UNI_SAT_HIGH    = 14'h3fff;

  // ==========================================================================
  // trim arithmetic: offset in 1/32 code, slope over 8*16384 or 4*16384
  localparam int OFFSET_FRAC_BITS = 5;
  localparam int BIP_SLOPE_SHIFT  = 17;
  localparam int UNI_SLOPE_SHIFT  = 16;

endpackage : qdc_pkg

// *** logic/qdc_core.sv ***
// control core of a four channel converter: serial frame, registers, latches
// assumes all pins are asynchronous to clk and much slower than 10 MHz
`timescale 1ns/1ps

module qdc_core (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             sclk,
  input  wire logic             cs_n,
  input  wire logic             sdi,
  input  wire logic             latch_load_n,
  input  wire logic             reset_pin_n,
  input  wire logic             range_select_group_a,
  input  wire logic             range_select_group_b,
  output logic [3:0][13:0]      latch_code,
  output logic [3:0][13:0]      corrected_code,
  output logic [3:0]            gain_x4,
  output logic [3:0]            unipolar,
  output logic [13:0]           read_data,
  output logic                  read_valid
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [6:0]        meta_reg;
  logic [6:0]        sync_reg;
  logic [2:0]        edge_reg;
  logic [1:0]        por_cnt_reg;
  logic              soft_rst_reg;
  logic [23:0]       shift_reg;
  logic [4:0]        bit_cnt_reg;
  logic [3:0][13:0]  input_reg;
  logic [3:0][13:0]  latch_reg;
  logic [3:0][8:0]   offset_reg;
  logic [3:0][7:0]   slope_reg;
  logic [3:0]        written_reg;
  logic [3:0]        gain_reg;
  logic [13:0]       read_data_reg;
  logic              read_valid_reg;
  logic              sclk_fall;
  logic              cs_fall;
  logic              cs_rise;
  logic              load_fall;
  logic              load_low;
  logic              hw_rst_n_s;
  logic              reset_all;
  logic              commit;
  logic              wr;
  logic              rd;
  logic              cmd_wr;
  logic              global_load;
  logic [3:0]        fr_addr;
  logic [13:0]       fr_data;
  logic [3:0]        wr_in;
  logic [3:0]        wr_off;
  logic [3:0]        wr_slope;
  logic [8:0]        offset_clamped;
  logic [7:0]        slope_clamped;
  logic [13:0]       read_mux;

  function automatic logic [13:0] reset_code(input logic uni);
    return uni ? qdc_pkg::RESET_CODE_UNI : qdc_pkg::RESET_CODE_BIP;
  endfunction : reset_code

  // ==========================================================================
  // pin synchronisers and edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= qdc_pkg::SYNC_INIT;
      sync_reg <= qdc_pkg::SYNC_INIT;
    end else begin
      meta_reg <= {range_select_group_b, range_select_group_a, sdi, reset_pin_n,
                   latch_load_n, cs_n, sclk};
      sync_reg <= meta_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_reg <= qdc_pkg::SYNC_INIT[2:0];
    end else begin
      edge_reg <= sync_reg[2:0];
    end
  end

  assign sclk_fall  = edge_reg[0] & ~sync_reg[0];
  assign cs_fall    = edge_reg[1] & ~sync_reg[1];
  assign cs_rise    = ~edge_reg[1] & sync_reg[1];
  assign load_fall  = edge_reg[2] & ~sync_reg[2];
  assign load_low   = ~sync_reg[2];
  assign hw_rst_n_s = sync_reg[3];
  assign unipolar   = {sync_reg[6], sync_reg[6], sync_reg[5], sync_reg[5]};

  // ==========================================================================
  // reset sources: power-on load, reset pin, software reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt_reg <= 2'h0;
    end else if (por_cnt_reg != qdc_pkg::POR_CYCLES) begin
      por_cnt_reg <= por_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= cmd_wr & fr_data[qdc_pkg::CMD_RST_BIT];
    end
  end

  assign reset_all = (por_cnt_reg != qdc_pkg::POR_CYCLES) | ~hw_rst_n_s | soft_rst_reg;

  // ==========================================================================
  // serial frame capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg   <= 24'h00_0000;
      bit_cnt_reg <= 5'h00;
    end else if (reset_all) begin
      shift_reg   <= 24'h00_0000;
      bit_cnt_reg <= 5'h00;
    end else if (cs_fall) begin
      bit_cnt_reg <= 5'h00;
    end else if (!sync_reg[1] && sclk_fall) begin
      shift_reg <= {shift_reg[22:0], sync_reg[4]};
      if (bit_cnt_reg != qdc_pkg::FRAME_BITS) begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
    end
  end

  assign commit  = cs_rise & (bit_cnt_reg == qdc_pkg::FRAME_BITS) & ~reset_all;
  assign fr_addr = shift_reg[qdc_pkg::ADDR_MSB:qdc_pkg::ADDR_LSB];
  assign fr_data = shift_reg[qdc_pkg::DATA_MSB:0];
  assign wr      = commit & ~shift_reg[qdc_pkg::RW_BIT];
  assign rd      = commit & shift_reg[qdc_pkg::RW_BIT];
  assign cmd_wr  = wr & (fr_addr == qdc_pkg::ADDR_COMMAND);
  assign global_load = load_fall | (cmd_wr & fr_data[qdc_pkg::CMD_LOAD_BIT]);

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wr_in[i]    = wr & (fr_addr[3:2] == qdc_pkg::BANK_INPUT) & (fr_addr[1:0] == 2'(i));
      wr_off[i]   = wr & (fr_addr[3:2] == qdc_pkg::BANK_OFFSET) & (fr_addr[1:0] == 2'(i));
      wr_slope[i] = wr & (fr_addr[3:2] == qdc_pkg::BANK_SLOPE) & (fr_addr[1:0] == 2'(i));
    end
  end

  // ==========================================================================
  // trim limits on write
  always_comb begin
    if ($signed(fr_data) < qdc_pkg::OFFSET_TRIM_MIN) begin
      offset_clamped = 9'(qdc_pkg::OFFSET_TRIM_MIN);
    end else if ($signed(fr_data) > qdc_pkg::OFFSET_TRIM_MAX) begin
      offset_clamped = 9'(qdc_pkg::OFFSET_TRIM_MAX);
    end else begin
      offset_clamped = fr_data[8:0];
    end
    if ($signed(fr_data) < qdc_pkg::SLOPE_TRIM_MIN) begin
      slope_clamped = 8'(qdc_pkg::SLOPE_TRIM_MIN);
    end else if ($signed(fr_data) > qdc_pkg::SLOPE_TRIM_MAX) begin
      slope_clamped = 8'(qdc_pkg::SLOPE_TRIM_MAX);
    end else begin
      slope_clamped = fr_data[7:0];
    end
  end

  // ==========================================================================
  // input registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      input_reg <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (reset_all) begin
          input_reg[i] <= reset_code(unipolar[i]);
        end else if (wr_in[i]) begin
          input_reg[i] <= fr_data;
        end
      end
    end
  end

  // ==========================================================================
  // output latches, held until a load event
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (reset_all) begin
          latch_reg[i] <= reset_code(unipolar[i]);
        end else if (wr_in[i] && load_low) begin
          latch_reg[i] <= fr_data;
        end else if (global_load && written_reg[i]) begin
          latch_reg[i] <= input_reg[i];
        end
      end
    end
  end

  // ==========================================================================
  // written flags, a write in the same cycle as a load leaves the flag clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      written_reg <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (reset_all) begin
          written_reg[i] <= 1'b0;
        end else if (wr_in[i] && !load_low) begin
          written_reg[i] <= 1'b1;
        end else if ((wr_in[i] && load_low) || global_load) begin
          written_reg[i] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // trim registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      offset_reg <= '0;
      slope_reg  <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (reset_all) begin
          offset_reg[i] <= qdc_pkg::OFFSET_RESET;
          slope_reg[i]  <= qdc_pkg::SLOPE_RESET;
        end else begin
          if (wr_off[i]) begin
            offset_reg[i] <= offset_clamped;
          end
          if (wr_slope[i]) begin
            slope_reg[i] <= slope_clamped;
          end
        end
      end
    end
  end

  // ==========================================================================
  // command register gain bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_reg <= qdc_pkg::GAIN_RESET;
    end else if (reset_all) begin
      gain_reg <= qdc_pkg::GAIN_RESET;
    end else if (cmd_wr) begin
      gain_reg <= fr_data[qdc_pkg::CMD_GAIN_MSB:qdc_pkg::CMD_GAIN_LSB];
    end
  end

  // ==========================================================================
  // read back in write format
  always_comb begin
    case (fr_addr[3:2])
      qdc_pkg::BANK_INPUT:  read_mux = input_reg[fr_addr[1:0]];
      qdc_pkg::BANK_OFFSET: read_mux = 14'($signed(offset_reg[fr_addr[1:0]]));
      qdc_pkg::BANK_SLOPE:  read_mux = 14'($signed(slope_reg[fr_addr[1:0]]));
      default: read_mux = (fr_addr == qdc_pkg::ADDR_COMMAND) ? {10'h000, gain_reg} : 14'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_data_reg  <= 14'h0000;
      read_valid_reg <= 1'b0;
    end else begin
      read_valid_reg <= rd;
      if (rd) begin
        read_data_reg <= read_mux;
      end
    end
  end

  // ==========================================================================
  // per channel trim and outputs
  for (genvar g = 0; g < 4; g++) begin : gen_ch
    qdc_trim u_trim (
      .clk           (clk),
      .rst_n         (rst_n),
      .code          (latch_reg[g]),
      .offset_trim   (offset_reg[g]),
      .slope_trim    (slope_reg[g]),
      .unipolar      (unipolar[g]),
      .corrected_reg (corrected_code[g])
    );
    AST_INDIVIDUAL: assert property (wr_in[g] && load_low
                                     |=> latch_reg[g] == $past(fr_data))
      else $error("individual update missed latch");
    AST_HOLD_UNWRITTEN: assert property (global_load && !written_reg[g] && !wr_in[g]
                                         && !reset_all |=> $stable(latch_reg[g]))
      else $error("unwritten channel reloaded");
    AST_DEFERRED: assert property (wr_in[g] && !load_low |=> written_reg[g]
                                   && $stable(latch_reg[g]))
      else $error("deferred write changed latch");
    AST_LOAD_CLEARS: assert property (global_load && written_reg[g] && !wr_in[g]
                                      && !reset_all |=> !written_reg[g]
                                      && latch_reg[g] == $past(input_reg[g]))
      else $error("load did not take input register");
    AST_INPUT_WRITE: assert property (wr_in[g] |=> input_reg[g] == $past(fr_data))
      else $error("input register not written");
  end
  // ==========================================================================
  // block level checks
  AST_SHORT_FRAME: assert property (cs_rise && bit_cnt_reg != qdc_pkg::FRAME_BITS
                                    && !reset_all |=> $stable(input_reg) && $stable(offset_reg)
                                    && $stable(slope_reg) && !read_valid_reg)
    else $error("short frame changed state");
  AST_HW_RESET: assert property (!hw_rst_n_s |=> input_reg == '0 && latch_reg == '0
                                 && offset_reg == '0 && slope_reg == '0)
    else $error("hardware reset left registers set");
  AST_SERIAL_OFF: assert property (!hw_rst_n_s |=> bit_cnt_reg == 5'h00
                                   ##1 !read_valid_reg)
    else $error("serial active during reset");
  AST_SOFT_CLEAR: assert property (soft_rst_reg |=> !soft_rst_reg
                                   && gain_reg == qdc_pkg::GAIN_RESET && written_reg == 4'h0)
    else $error("software reset did not act or clear");
  AST_GAIN_DEFAULT: assert property ($fell(reset_all) |-> gain_reg == qdc_pkg::GAIN_RESET)
    else $error("gain bits not one after reset");

  assign latch_code = latch_reg;
  assign gain_x4    = gain_reg;
  assign read_data  = read_data_reg;
  assign read_valid = read_valid_reg;

endmodule : qdc_core

// *** logic/qdc_trim.sv ***
// offset and slope trim of one channel, registered and saturated
// assumes code, trims and range come from registers on the same clock
`timescale 1ns/1ps

module qdc_trim (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [13:0]        code,
  input  wire logic signed [8:0]  offset_trim,
  input  wire logic signed [7:0]  slope_trim,
  input  wire logic               unipolar,
  output logic      [13:0]        corrected_reg
);

  logic signed [14:0] code_ext;
  logic signed [20:0] fine;
  logic signed [28:0] prod;
  logic signed [28:0] scaled;
  logic signed [29:0] sum;
  logic signed [24:0] whole;
  logic        [13:0] corrected_next;

  // ==========================================================================
  // transfer arithmetic
  always_comb begin
    code_ext = unipolar ? $signed({1'b0, code}) : $signed({code[13], code});
    fine     = (21'(code_ext) <<< qdc_pkg::OFFSET_FRAC_BITS) + 21'(offset_trim);
    prod     = 29'(fine) * 29'(slope_trim);
    scaled   = unipolar ? (prod >>> qdc_pkg::UNI_SLOPE_SHIFT)
                        : (prod >>> qdc_pkg::BIP_SLOPE_SHIFT);
    sum      = 30'(fine) + 30'(scaled);
    whole    = 25'(sum >>> qdc_pkg::OFFSET_FRAC_BITS);
    if (unipolar) begin
      if (whole < 0) begin
        corrected_next = qdc_pkg::UNI_SAT_LOW;
      end else if (whole > qdc_pkg::UNI_CODE_MAX) begin
        corrected_next = qdc_pkg::UNI_SAT_HIGH;
      end else begin
        corrected_next = whole[13:0];
      end
    end else begin
      if (whole < qdc_pkg::BIP_CODE_MIN) begin
        corrected_next = qdc_pkg::BIP_SAT_LOW;
      end else if (whole > qdc_pkg::BIP_CODE_MAX) begin
        corrected_next = qdc_pkg::BIP_SAT_HIGH;
      end else begin
        corrected_next = whole[13:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      corrected_reg <= qdc_pkg::RESET_CODE_BIP;
    end else begin
      corrected_reg <= corrected_next;
    end
  end

endmodule : qdc_trim

// *** testbench/qdc_core_tb_top.sv ***
// bench for the quad converter control core: host model, read scoreboard
// assumes the design takes a frame 3 clk after cs_n rises and answers reads with read_valid
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", nm, exp, got); end end

module qdc_core_tb_top;
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             range_select_group_a = 1'b0;
  logic             range_select_group_b = 1'b0;
  logic             sclk, cs_n, sdi, latch_load_n, reset_pin_n;
  logic [3:0][13:0] latch_code, corrected_code;
  logic [3:0]       gain_x4, unipolar;
  logic [13:0]      read_data, e, v;
  logic             read_valid;
  logic [13:0]      rq[$];
  int               n_fail = 0;
  int               checks = 0;
  int               cyc = 0;

  always #50 clk = ~clk;

  qdc_host_model u_qdc_host_model (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .latch_load_n(latch_load_n), .reset_pin_n(reset_pin_n));

  qdc_core u_qdc_core (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .latch_load_n(latch_load_n), .reset_pin_n(reset_pin_n),
    .range_select_group_a(range_select_group_a), .range_select_group_b(range_select_group_b),
    .latch_code(latch_code), .corrected_code(corrected_code), .gain_x4(gain_x4),
    .unipolar(unipolar), .read_data(read_data), .read_valid(read_valid));

  // ==========================================================================
  // read scoreboard: oldest note against each read_valid pulse
  always @(posedge clk) begin
    if (read_valid === 1'b1) begin
      e = (rq.size() > 0) ? rq.pop_front() : 14'hxxxx;
      `CHK("read_data", e, read_data)
    end
  end

  task automatic results();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      results();
    end
  end

  // ==========================================================================
  // access tasks
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w

  task automatic wr(input logic [3:0] a, input logic [13:0] d, input logic load_now);
    u_qdc_host_model.frame({1'b0, a, 5'h00, d}, 24, load_now);
    w(8);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [13:0] x);
    rq.push_back(x);
    u_qdc_host_model.frame({1'b1, a, 5'h00, 14'h0000}, 24, 1'b0);
    w(8);
  endtask : rd

  // ==========================================================================
  // scenarios
  initial begin
    void'($urandom(90667));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    w(12);
    `CHK("gain_x4", 4'hf, gain_x4)
    `CHK("latch_code", 56'h0, latch_code)
    `CHK("corrected_code", 56'h0, corrected_code)
    rd({qdc_pkg::BANK_SLOPE, 2'h2}, 14'h0000);
    wr(qdc_pkg::ADDR_COMMAND, 14'h0000, 1'b0);
    `CHK("gain_x4", 4'h0, gain_x4)
    rd(qdc_pkg::ADDR_COMMAND, 14'h0000);
    wr({qdc_pkg::BANK_INPUT, 2'h1}, 14'h0123, 1'b0);
    `CHK("latch_code1", 14'h0000, latch_code[1])
    rd({qdc_pkg::BANK_INPUT, 2'h1}, 14'h0123);
    u_qdc_host_model.frame({1'b0, qdc_pkg::BANK_INPUT, 2'h1, 5'h00, 14'h0777}, 20, 1'b0);
    w(8);
    rd({qdc_pkg::BANK_INPUT, 2'h1}, 14'h0123);
    u_qdc_host_model.pulse_load();
    w(8);
    `CHK("latch_code1", 14'h0123, latch_code[1])
    `CHK("latch_code0", 14'h0000, latch_code[0])
    `CHK("corrected_code1", 14'h0123, corrected_code[1])
    v = 14'($urandom()) | 14'h0001;
    wr({qdc_pkg::BANK_INPUT, 2'h2}, v, 1'b1);
    `CHK("latch_code2", v, latch_code[2])
    `CHK("latch_code1", 14'h0123, latch_code[1])
    wr({qdc_pkg::BANK_INPUT, 2'h0}, 14'h0abc, 1'b0);
    `CHK("latch_code0", 14'h0000, latch_code[0])
    wr(qdc_pkg::ADDR_COMMAND, 14'h1000, 1'b0);
    `CHK("latch_code0", 14'h0abc, latch_code[0])
    `CHK("latch_code2", v, latch_code[2])
    wr({qdc_pkg::BANK_OFFSET, 2'h0}, 14'h012c, 1'b0);
    rd({qdc_pkg::BANK_OFFSET, 2'h0}, 14'h00ff);
    wr({qdc_pkg::BANK_SLOPE, 2'h0}, 14'h3f38, 1'b0);
    rd({qdc_pkg::BANK_SLOPE, 2'h0}, 14'h3f80);
    wr({qdc_pkg::BANK_SLOPE, 2'h0}, 14'h0000, 1'b0);
    wr({qdc_pkg::BANK_INPUT, 2'h0}, 14'h1fff, 1'b1);
    `CHK("corrected_code0", 14'h1fff, corrected_code[0])
    wr({qdc_pkg::BANK_SLOPE, 2'h0}, 14'h007f, 1'b0);
    wr({qdc_pkg::BANK_INPUT, 2'h0}, 14'h1000, 1'b1);
    `CHK("corrected_code0", 14'h100b, corrected_code[0])
    @(posedge clk);
    range_select_group_b <= 1'b1;
    w(10);
    `CHK("unipolar", 4'b1100, unipolar)
    wr({qdc_pkg::BANK_SLOPE, 2'h3}, 14'h007f, 1'b0);
    wr({qdc_pkg::BANK_INPUT, 2'h3}, 14'h3000, 1'b1);
    `CHK("corrected_code3", 14'h3017, corrected_code[3])
    wr(qdc_pkg::ADDR_COMMAND, 14'h2000, 1'b0);
    `CHK("gain_x4", 4'hf, gain_x4)
    `CHK("latch_code", 56'h0, latch_code)
    rd({qdc_pkg::BANK_OFFSET, 2'h0}, 14'h0000);
    rd(qdc_pkg::ADDR_COMMAND, 14'h000f);
    wr({qdc_pkg::BANK_INPUT, 2'h3}, 14'h0555, 1'b1);
    wr(qdc_pkg::ADDR_COMMAND, 14'h0000, 1'b0);
    u_qdc_host_model.set_reset_pin(1'b0);
    w(6);
    `CHK("latch_code3", 14'h0000, latch_code[3])
    `CHK("gain_x4", 4'hf, gain_x4)
    fork
      u_qdc_host_model.frame({1'b0, qdc_pkg::BANK_INPUT, 2'h2, 5'h00, 14'h0aaa}, 24, 1'b1);
      begin
        w(30);
        u_qdc_host_model.set_reset_pin(1'b1);
      end
    join
    w(10);
    `CHK("latch_code", 56'h0, latch_code)
    rd({qdc_pkg::BANK_INPUT, 2'h2}, 14'h0000);
    `CHK("queue_left", 0, rq.size())
    results();
  end
endmodule : qdc_core_tb_top

// *** testbench/qdc_host_model.sv ***
// serial host model: frames on cs_n/sclk/sdi, load and reset pins
// assumes clk is 10 MHz and every pin change is made just after a clk edge
`timescale 1ns/1ps

module qdc_host_model (
  input  wire logic clk,
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  output logic      latch_load_n,
  output logic      reset_pin_n
);
  // ==========================================================================
  // idle levels
  initial begin
    sclk         = 1'b1;
    cs_n         = 1'b1;
    sdi          = 1'b0;
    latch_load_n = 1'b1;
    reset_pin_n  = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // ==========================================================================
  // frame of n bits msb first, each sclk phase 4 clk, load pin held through commit
  task automatic frame(input logic [23:0] w, input int n, input logic load_low);
    int i;
    tick(1);
    latch_load_n <= ~load_low;
    cs_n         <= 1'b0;
    for (i = 23; i > 23 - n; i--) begin
      tick(1);
      sdi  <= w[i];
      sclk <= 1'b1;
      tick(4);
      sclk <= 1'b0;
      tick(3);
    end
    tick(1);
    sclk <= 1'b1;
    tick(3);
    cs_n <= 1'b1;
    sdi  <= ~sdi;
    tick(6);
    latch_load_n <= 1'b1;
  endtask : frame

  task automatic pulse_load();
    tick(1);
    latch_load_n <= 1'b0;
    tick(5);
    latch_load_n <= 1'b1;
    tick(1);
  endtask : pulse_load

  task automatic set_reset_pin(input logic v);
    tick(1);
    reset_pin_n <= v;
  endtask : set_reset_pin
endmodule : qdc_host_model
